// file: hw/amc_mode_ctrl.v
`timescale 1ns/1ps
`include "amc_consts.vh"
module amc_mode_ctrl #(
  parameter [19:0] DLY1 = 20'd`AMC_DLY1_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY2 = 20'd`AMC_DLY2_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY3 = 20'd`AMC_DLY3_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY4 = 20'd`AMC_DLY4_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY5 = 20'd`AMC_DLY5_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY6 = 20'd`AMC_DLY6_US * 20'd`AMC_CLK_MHZ,
  parameter [19:0] DLY7 = 20'd`AMC_DLY7_US * 20'd`AMC_CLK_MHZ
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [5:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  output reg  [15:0] o_reg_rdata,
  output wire        o_reg_hit,
  input  wire        i_chan_switch,
  input  wire        i_result_valid,
  input  wire [3:0]  i_result_chan,
  input  wire        i_data_read,
  output wire        o_filter_reset,
  output wire        o_conv_start,
  output wire        o_settle_busy,
  output wire        o_ref_enable,
  output wire        o_reference_output_pin_en,
  output wire        o_settled_only_output,
  output wire [2:0]  o_op_mode,
  output wire [1:0]  o_master_clock_source_select,
  output wire        o_int_osc_enable,
  output wire        o_clock_io_pin_oe,
  output wire        o_crystal_input_pin_en,
  output wire        o_ready_b,
  output wire [3:0]  o_status_chan
);

  //////////////////////////////////////////////////////////////////////////
  // Register write

  reg [15:0] converter_mode_control;
  reg [15:0] next_converter_mode_control;
  reg        wr_pulse;
  reg [15:0] next_reg_rdata;
  reg        ready_b;
  reg        next_ready_b;
  reg [3:0]  status_chan;
  reg [3:0]  next_status_chan;
  reg        int_osc_en;
  reg        clk_io_oe;
  reg        xtal_en;

  function is_mode_addr;
    input [5:0] addr;
    begin
      is_mode_addr = (addr == `AMC_ADDR_MODE);
    end
  endfunction

  function run_after_write;
    input [2:0] mode;
    begin
      run_after_write = (mode != `AMC_OPM_STANDBY) &&
                        (mode != `AMC_OPM_PWRDN);
    end
  endfunction

  wire mode_wr = i_reg_wr && is_mode_addr(i_reg_addr);

  assign o_reg_hit = is_mode_addr(i_reg_addr);

  always @* begin
    next_converter_mode_control = converter_mode_control;
    if (mode_wr) begin
      // Unused bits are dropped; host must write them as zero
      next_converter_mode_control = i_reg_wdata & `AMC_MODE_WMASK;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      converter_mode_control <= `AMC_MODE_RESET;
      wr_pulse               <= 1'b0;
    end else begin
      converter_mode_control <= next_converter_mode_control;
      wr_pulse               <= mode_wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readback

  // Other addresses read as zero
  always @* begin
    next_reg_rdata = o_reg_rdata;
    if (i_reg_rd && is_mode_addr(i_reg_addr)) begin
      next_reg_rdata = converter_mode_control & `AMC_MODE_WMASK;
    end else if (i_reg_rd) begin
      next_reg_rdata = 16'h0000;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_rdata <= next_reg_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Field decode

  wire [2:0] opm      = converter_mode_control[`AMC_OPM_HI:`AMC_OPM_LO];
  wire [1:0] clk_sel  = converter_mode_control[`AMC_CLK_HI:`AMC_CLK_LO];
  wire [2:0] dly_code = converter_mode_control[`AMC_DLY_HI:`AMC_DLY_LO];

  assign o_ref_enable = converter_mode_control[`AMC_REF_EN_BIT];
  assign o_reference_output_pin_en =
    converter_mode_control[`AMC_REF_EN_BIT];
  assign o_settled_only_output =
    converter_mode_control[`AMC_SETTLED_BIT];
  assign o_op_mode = opm;
  assign o_master_clock_source_select = clk_sel;

  always @* begin
    int_osc_en = 1'b0;
    clk_io_oe  = 1'b0;
    xtal_en    = 1'b0;
    case (clk_sel)
      `AMC_CLK_INT: begin
        int_osc_en = 1'b1;
      end
      `AMC_CLK_INT_OUT: begin
        int_osc_en = 1'b1;
        clk_io_oe  = 1'b1;
      end
      `AMC_CLK_XTAL: begin
        xtal_en = 1'b1;
      end
      default: begin
        // External clock needs no local source
        int_osc_en = 1'b0;
      end
    endcase
  end

  assign o_int_osc_enable       = int_osc_en;
  assign o_clock_io_pin_oe      = clk_io_oe;
  assign o_crystal_input_pin_en = xtal_en;

  // Fresh run after write unless standby or power-down
  assign o_filter_reset = wr_pulse;
  assign o_conv_start   = wr_pulse && run_after_write(opm);

  //////////////////////////////////////////////////////////////////////////
  // Channel-switch settling wait

  // Mode write aborts a pending wait
  amc_delay_timer #(
    .DLY1 (DLY1),
    .DLY2 (DLY2),
    .DLY3 (DLY3),
    .DLY4 (DLY4),
    .DLY5 (DLY5),
    .DLY6 (DLY6),
    .DLY7 (DLY7)
  ) u_delay (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (i_chan_switch),
    .i_abort   (wr_pulse),
    .i_code    (dly_code),
    .o_busy    (o_settle_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // Ready flag and result channel

  // Write restarts the filter, so an in-flight result is stale
  wire result_take = i_result_valid && !mode_wr && !wr_pulse;

  // New result beats a data read in the same cycle
  always @* begin
    next_ready_b     = ready_b;
    next_status_chan = status_chan;
    if (result_take) begin
      next_ready_b     = 1'b0;
      next_status_chan = i_result_chan;
    end else if (i_data_read || mode_wr) begin
      next_ready_b = 1'b1;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ready_b     <= 1'b1;
      status_chan <= 4'h0;
    end else begin
      ready_b     <= next_ready_b;
      status_chan <= next_status_chan;
    end
  end

  assign o_ready_b     = ready_b;
  assign o_status_chan = status_chan;

endmodule

// file: hw/amc_consts.vh
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH

// Register addressing
`define AMC_ADDR_W          6
`define AMC_ADDR_MODE       6'h01
`define AMC_MODE_RESET      16'h2000
`define AMC_MODE_WMASK      16'hA77C

// Mode register fields
`define AMC_REF_EN_BIT      15
`define AMC_SETTLED_BIT     13
`define AMC_DLY_HI          10
`define AMC_DLY_LO          8
`define AMC_OPM_HI          6
`define AMC_OPM_LO          4
`define AMC_CLK_HI          3
`define AMC_CLK_LO          2

// Operating modes
`define AMC_OPM_CONT        3'h0
`define AMC_OPM_SINGLE      3'h1
`define AMC_OPM_STANDBY     3'h2
`define AMC_OPM_PWRDN       3'h3

// Clock source codes
`define AMC_CLK_INT         2'h0
`define AMC_CLK_INT_OUT     2'h1
`define AMC_CLK_EXT         2'h2
`define AMC_CLK_XTAL        2'h3

// Channel-switch delays in microseconds, clock at 100 MHz
`define AMC_CLK_MHZ         100
`define AMC_DLY0_US         0
`define AMC_DLY1_US         16
`define AMC_DLY2_US         64
`define AMC_DLY3_US         160
`define AMC_DLY4_US         400
`define AMC_DLY5_US         800
`define AMC_DLY6_US         3000
`define AMC_DLY7_US         4000
`define AMC_CNT_W           20

`endif

// file: hw/amc_delay_timer.v
`timescale 1ns/1ps
// Settling wait counter loaded on each channel switch, unless an abort arrives in the same cycle
module amc_delay_timer #(
  parameter [19:0] DLY1 = 20'h00640,
  parameter [19:0] DLY2 = 20'h01900,
  parameter [19:0] DLY3 = 20'h03E80,
  parameter [19:0] DLY4 = 20'h09C40,
  parameter [19:0] DLY5 = 20'h13880,
  parameter [19:0] DLY6 = 20'h493E0,
  parameter [19:0] DLY7 = 20'h61A80
) (
  input  wire       i_sys_clk,
  input  wire       i_rst_b,
  input  wire       i_start,
  input  wire       i_abort,
  input  wire [2:0] i_code,
  output wire       o_busy
);

  reg [19:0] cnt;

  function [19:0] dly_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h1:    dly_cycles = DLY1;
        3'h2:    dly_cycles = DLY2;
        3'h3:    dly_cycles = DLY3;
        3'h4:    dly_cycles = DLY4;
        3'h5:    dly_cycles = DLY5;
        3'h6:    dly_cycles = DLY6;
        3'h7:    dly_cycles = DLY7;
        default: dly_cycles = 20'h00000;
      endcase
    end
  endfunction

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 20'h00000;
    end else if (i_abort) begin
      cnt <= 20'h00000;
    end else if (i_start) begin
      cnt <= dly_cycles(i_code);
    end else if (cnt != 20'h00000) begin
      cnt <= cnt - 20'h00001;
    end
  end

  assign o_busy = (cnt != 20'h00000);

endmodule

// file: dv/amc_props.sv
`timescale 1ns/1ps
module amc_props (
  input wire        i_sys_clk,
  input wire        i_rst_b,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [5:0]  i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  input wire        i_result_valid,
  input wire [3:0]  i_result_chan,
  input wire        i_data_read,
  input wire        o_filter_reset,
  input wire        o_conv_start,
  input wire        o_ref_enable,
  input wire        o_reference_output_pin_en,
  input wire [2:0]  o_op_mode,
  input wire [1:0]  o_master_clock_source_select,
  input wire        o_int_osc_enable,
  input wire        o_ready_b,
  input wire [3:0]  o_status_chan
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_mwr; i_reg_wr && i_reg_addr == 6'h01; endsequence
  sequence s_res; i_result_valid && !i_reg_wr && !o_filter_reset; endsequence
  AST_WR_PULSE: assert property (s_mwr |=> o_filter_reset && o_ready_b)
    else $error("no restart");
  AST_NO_SPUR: assert property (o_filter_reset |->
    $past(i_reg_wr && i_reg_addr == 6'h01))
    else $error("stray restart");
  AST_CONV: assert property (o_conv_start ==
    (o_filter_reset && o_op_mode[2:1] != 2'h1)) else $error("bad start");
  AST_RDY_SET: assert property (s_res |=>
    !o_ready_b && o_status_chan == $past(i_result_chan)) else $error("rdy");
  AST_RDY_CLR: assert property (i_data_read && !i_result_valid
    |=> o_ready_b) else $error("rdy stuck");
  AST_RD_ZERO: assert property (i_reg_rd && !i_reg_wr |=>
    (o_reg_rdata & 16'h5883) == 16'h0000) else $error("reserved set");
  AST_OSC: assert property (o_int_osc_enable ==
    !o_master_clock_source_select[1]) else $error("osc");
  AST_REF: assert property ((o_reference_output_pin_en == o_ref_enable)
    and (s_mwr |=> o_ref_enable == $past(i_reg_wdata[15])))
    else $error("ref");
endmodule
bind amc_mode_ctrl amc_props i_amc_props (.*);

// file: dv/amc_host.sv
`timescale 1ns/1ps
module amc_host (
  input  wire        i_sys_clk,
  output reg         o_wr,
  output reg         o_rd,
  output reg  [5:0]  o_addr,
  output reg  [15:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 24'h000000;
  // Released lines show the inverse of the last value
  task wr(input [5:0] a, input [15:0] d, input raw);
    @(negedge i_sys_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, raw ? d : d & 16'hA77C};
    @(negedge i_sys_clk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~o_wdata};
  endtask
  task rd(input [5:0] a);
    @(negedge i_sys_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_sys_clk);
    {o_rd, o_addr} = {1'b0, ~a};
  endtask
endmodule

// file: dv/adc_mode_control_register_bench.sv
`timescale 1ns/1ps
module adc_mode_control_register_bench;
  reg         clk = 0, rst_b = 0, sw = 0, rv = 0, dr = 0;
  reg  [3:0]  rch = 0;
  wire        wr, rd, cst, bsy, rp, sng, osc, cio, xt, rdyb;
  wire        hit, frst, rfe;
  wire [1:0]  csel;
  wire [15:0] wd, rdat;
  wire [5:0]  ad;
  wire [2:0]  opm;
  wire [3:0]  sch;
  integer     fails = 0, samples_checked = 0, k, n;
  always #5 clk = ~clk;
  amc_host i_amc_host (.i_sys_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(ad),
    .o_wdata(wd));
  amc_mode_ctrl #(.DLY1(20'h4), .DLY2(20'h5), .DLY3(20'h6), .DLY4(20'h7),
    .DLY5(20'h8), .DLY6(20'h9), .DLY7(20'hA)) i_amc_mode_ctrl (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_hit(hit),
    .i_chan_switch(sw), .i_result_valid(rv), .i_result_chan(rch),
    .i_data_read(dr), .o_filter_reset(frst), .o_conv_start(cst),
    .o_settle_busy(bsy), .o_ref_enable(rfe), .o_reference_output_pin_en(rp),
    .o_settled_only_output(sng), .o_op_mode(opm),
    .o_master_clock_source_select(csel), .o_int_osc_enable(osc),
    .o_clock_io_pin_oe(cio), .o_crystal_input_pin_en(xt),
    .o_ready_b(rdyb), .o_status_chan(sch));
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] e, input [15:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdm(input [15:0] e);
    i_amc_host.rd(6'h01);
    chk("mode", e, rdat);
  endtask
  task finish_test;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1;
    rdm(16'h2000);
    chk("osc", 1, osc);
    chk("settled", 1, sng);
    chk("ref", 0, rfe);
    i_amc_host.rd(6'h3E);
    chk("other", 0, rdat);
    chk("hit", 1, hit);
    i_amc_host.wr(6'h01, 16'hFFFF, 1);
    chk("freset", 1, frst);
    rdm(16'hA77C);
    chk("ref", 1, rfe);
    chk("refpin", 1, rp);
    chk("xtal", 1, xt);
    i_amc_host.wr(6'h02, 16'h0000, 0);
    rdm(16'hA77C);
    $display("test regs done");
    for (k = 0; k < 8; k = k + 1) begin
      i_amc_host.wr(6'h01, {k[2:0], 4'h0}, 0);
      chk("start", k != 2 && k != 3, cst);
      chk("opmode", k, opm);
    end
    chk("settled", 0, sng);
    for (k = 0; k < 4; k = k + 1) begin
      i_amc_host.wr(6'h01, {k[1:0], 2'h0}, 0);
      chk("osc", k < 2, osc);
      chk("clksel", k, csel);
      chk("clkio", k == 1, cio);
    end
    $display("test modes done");
    for (k = 0; k < 16; k = k + 5) begin
      @(negedge clk);
      rv = 1;
      rch = k[3:0];
      @(negedge clk);
      rv = 0;
      chk("ready", 0, rdyb);
      chk("chan", k, sch);
      dr = k < 15;
      @(negedge clk);
      dr = 0;
      chk("ready", k < 15, rdyb);
    end
    i_amc_host.wr(6'h01, 16'h0000, 0);
    chk("ready", 1, rdyb);
    chk("freset", 1, frst);
    $display("test ready done");
    for (k = 0; k < 8; k = k + 1) begin
      i_amc_host.wr(6'h01, {k[2:0], 8'h00}, 0);
      @(negedge clk);
      sw = 1;
      @(negedge clk);
      sw = 0;
      n = 0;
      repeat (12) begin
        if (bsy === 1'b1) n = n + 1;
        @(negedge clk);
      end
      chk("settle", k ? k + 3 : 0, n[15:0]);
    end
    $display("test settle done");
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    rdm(16'h2000);
    chk("settled", 1, sng);
    chk("ready", 1, rdyb);
    $display("test reset done");
    finish_test;
  end
endmodule
